//--- shared/tvd_cfg.svh
// trap_vector_dispatch constants: register offsets, trap codes, reset values
// assumes inclusion by bare name from the design files
`ifndef TVD_CFG_SVH
`define TVD_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TVD_ADR_TFR 8'h00
`define TVD_ADR_MASK 8'h04
`define TVD_ADR_NREQ 8'h08
`define TVD_ADR_NEN 8'h0c
`define TVD_ADR_NPRIO 8'h10
`define TVD_ADR_STAT 8'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define TVD_RST_MASK 8'h00
`define TVD_RST_NEN 8'h00
`define TVD_RST_NPRIO 32'h0000_0000

// ----------------------------------------
// trap flag bit positions
// ----------------------------------------
`define TVD_TFR_NMI 0
`define TVD_TFR_OVF 1
`define TVD_TFR_UNF 2
`define TVD_TFR_B_LO 3

// ----------------------------------------
// trap numbers, vector is four times the number
// ----------------------------------------
`define TVD_TRAP_RESET 7'h00
`define TVD_TRAP_NMI 7'h02
`define TVD_TRAP_OVF 7'h04
`define TVD_TRAP_UNF 7'h06
`define TVD_TRAP_CLASS_B 7'h0a
`define TVD_NODE_TRAPS {7'h43, 7'h42, 7'h41, 7'h40, 7'h2b, 7'h2a, 7'h21, 7'h20}

// ----------------------------------------
// trap service ranks and reset causes
// ----------------------------------------
`define TVD_RANK_NONE 2'h0
`define TVD_RANK_B 2'h1
`define TVD_RANK_A 2'h2
`define TVD_CAUSE_HW 2'h0
`define TVD_CAUSE_SW 2'h1
`define TVD_CAUSE_WDT 2'h2

`endif

//--- shared/tvd_pkg.sv
// trap_vector_dispatch types: dispatcher states and request sources
// assumes nothing beyond a SystemVerilog compiler
package tvd_pkg;
	typedef enum logic [1:0] {TVD_IDLE = 2'h1, TVD_OFFER = 2'h2} tvd_state_t;
	typedef enum logic [4:0] {
		TVD_SRC_RESET = 5'h01,
		TVD_SRC_CLASS_A = 5'h02,
		TVD_SRC_CLASS_B = 5'h04,
		TVD_SRC_SOFT = 5'h08,
		TVD_SRC_NODE = 5'h10
	} tvd_src_t;
endpackage : tvd_pkg

//--- verilog/tvd_flag_bank.sv
// sticky flag bank: per-bit set and clear, set wins
// assumes one clock core_clk and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module tvd_flag_bank #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flags_r
);
	logic [W-1:0] flags_nxt;
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			assign flags_nxt[i] = set[i] | (flags_r[i] & ~clr[i]);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end
endmodule : tvd_flag_bank
`default_nettype wire

//--- verilog/tvd_prio_pick.sv
// picks the enabled pending node with the highest priority level
// assumes level 0 means never serviced; lowest index wins a tie
`timescale 1ns/1ps
`default_nettype none
module tvd_prio_pick (
	input wire logic [7:0] req,
	input wire logic [7:0] en,
	input wire logic [31:0] prio,
	output logic [2:0] idx,
	output logic [3:0] lvl
);
	logic [3:0] elig [8];
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_node
			assign elig[i] = (req[i] & en[i]) ? prio[4*i +: 4] : 4'h0;
		end
	endgenerate

	always_comb
	begin
		idx = 3'h0;
		lvl = 4'h0;
		for (int k = 0; k < 8; k++)
		begin
			if (elig[k] > lvl)
			begin
				idx = 3'(k);
				lvl = elig[k];
			end
		end
	end
endmodule : tvd_prio_pick
`default_nettype wire

//--- verilog/tvd_top.sv
// trap and interrupt vector dispatcher with classic wishbone registers
// assumes cpu pulses take/return/trap inputs synchronous to core_clk
//
// Operation
// - each node has request, enable flag and vector equal to four times trap number
// - hardware traps dispatch ahead of soft traps and nodes, unmaskable, to their own vector
// - every hardware trap sets its own bit in the trap flag register
// - a trap waits only for a pending reset or while a trap service of equal or higher rank runs
// - during trap service, node interrupts and event controller transfers are blocked
// - class A: nmi 0x08/02, overflow 0x10/04, underflow 0x18/06
// - all five class B conditions share vector 0x28, trap 0x0a
// - nodes get sixteen levels; only a higher level preempts service
// - software writing a node request bit raises that request
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tvd_cfg.svh"
module tvd_top (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic nmi_i,
	input wire logic stack_ovf_i,
	input wire logic stack_unf_i,
	input wire logic undef_opcode_i,
	input wire logic prot_fault_i,
	input wire logic illegal_operand_i,
	input wire logic illegal_instr_i,
	input wire logic illegal_bus_i,
	input wire logic sw_reset_i,
	input wire logic wdt_ovf_i,
	input wire logic [7:0] node_req_i,
	input wire logic soft_trap_i,
	input wire logic [6:0] soft_trap_num_i,
	input wire logic disp_take_i,
	input wire logic svc_return_i,
	input wire logic [3:0] ret_level_i,
	input wire logic [1:0] ret_rank_i,
	output logic disp_valid_o,
	output logic [23:0] disp_vector_o,
	output logic [6:0] disp_trap_o,
	output logic [3:0] disp_level_o,
	output logic pec_allow_o,
	output logic irq_o
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [7:0] nen_r, nen_nxt;
	logic [31:0] nprio_r, nprio_nxt;
	logic [31:0] wmask;
	logic wr_en;
	logic [7:0] trap_flag_register;
	logic [7:0] trap_pend;
	logic [7:0] nreq;
	logic [1:0] cause_r, cause_nxt;
	logic soft_pend_r, soft_pend_nxt;
	logic [6:0] soft_num_r, soft_num_nxt;
	tvd_pkg::tvd_state_t state_r, state_nxt;
	tvd_pkg::tvd_src_t off_src_r, off_src_nxt;
	logic valid_r, valid_nxt;
	logic [6:0] off_trap_r, off_trap_nxt;
	logic [3:0] off_lvl_r, off_lvl_nxt;
	logic [1:0] off_rank_r, off_rank_nxt;
	logic [2:0] off_idx_r, off_idx_nxt;
	logic [7:0] off_clr_r, off_clr_nxt;
	logic [3:0] cur_level_r, cur_level_nxt;
	logic [1:0] cur_rank_r, cur_rank_nxt;
	logic rst_pend_r, rst_pend_nxt;
	logic pec_r, irq_r;

	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

	always_comb
	begin
		ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
		mask_nxt = mask_r;
		nen_nxt = nen_r;
		nprio_nxt = (nprio_r & ~wmask) | (wb_dat_i & wmask);
		rdat_nxt = 32'h0;
		if (!(wr_en && wb_adr_i == `TVD_ADR_NPRIO))
			nprio_nxt = nprio_r;
		if (wr_en && wb_sel_i[0] && wb_adr_i == `TVD_ADR_MASK)
			mask_nxt = wb_dat_i[7:0];
		if (wr_en && wb_sel_i[0] && wb_adr_i == `TVD_ADR_NEN)
			nen_nxt = wb_dat_i[7:0];
		case (wb_adr_i)
			`TVD_ADR_TFR: rdat_nxt = {24'h0, trap_flag_register};
			`TVD_ADR_MASK: rdat_nxt = {24'h0, mask_r};
			`TVD_ADR_NREQ: rdat_nxt = {24'h0, nreq};
			`TVD_ADR_NEN: rdat_nxt = {24'h0, nen_r};
			`TVD_ADR_NPRIO: rdat_nxt = nprio_r;
			`TVD_ADR_STAT: rdat_nxt = {14'h0, cause_r, 1'h0, off_trap_r,
				soft_pend_r, valid_r, cur_rank_r, cur_level_r};
			default: rdat_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_r <= 1'h0;
			rdat_r <= 32'h0;
			mask_r <= `TVD_RST_MASK;
			nen_r <= `TVD_RST_NEN;
			nprio_r <= `TVD_RST_NPRIO;
		end
		else
		begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
			mask_r <= mask_nxt;
			nen_r <= nen_nxt;
			nprio_r <= nprio_nxt;
		end
	end

	// ----------------------------------------
	// flags: trap flags, trap pending, node requests
	// ----------------------------------------
	logic [7:0] trap_evt;
	logic take;
	logic [7:0] nreq_wr_set, nreq_wr_clr, nreq_take_clr;
	logic nreq_wr;

	assign trap_evt = {illegal_bus_i, illegal_instr_i, illegal_operand_i, prot_fault_i,
		undef_opcode_i, stack_unf_i, stack_ovf_i, nmi_i};
	assign take = valid_r & disp_take_i;
	assign nreq_wr = wr_en & wb_sel_i[0] & (wb_adr_i == `TVD_ADR_NREQ);
	assign nreq_wr_set = nreq_wr ? wb_dat_i[7:0] : 8'h0;
	assign nreq_wr_clr = nreq_wr ? ~wb_dat_i[7:0] : 8'h0;
	assign nreq_take_clr = (take && off_src_r == tvd_pkg::TVD_SRC_NODE) ?
		(8'h1 << off_idx_r) : 8'h0;

	tvd_flag_bank #(.W(8)) u_tfr (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.set(trap_evt),
		.clr((wr_en && wb_sel_i[0] && wb_adr_i == `TVD_ADR_TFR) ? wb_dat_i[7:0] : 8'h0),
		.flags_r(trap_flag_register)
	);

	tvd_flag_bank #(.W(8)) u_trap_pend (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.set(trap_evt),
		.clr(take ? off_clr_r : 8'h0),
		.flags_r(trap_pend)
	);

	tvd_flag_bank #(.W(8)) u_nreq (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.set(node_req_i | nreq_wr_set),
		.clr(nreq_wr_clr | nreq_take_clr),
		.flags_r(nreq)
	);

	flag_set_a: assert property (trap_evt != 8'h0 |=> (trap_flag_register & $past(trap_evt)) == $past(trap_evt))
		else $error("trap event did not set its flag");

	sequence s_sw_write;
		nreq_wr && wb_dat_i[6];
	endsequence
	sw_request_a: assert property (s_sw_write |=> nreq[6])
		else $error("software request bit not raised");

	// ----------------------------------------
	// priority pick
	// ----------------------------------------
	logic [2:0] best_idx;
	logic [3:0] best_lvl;
	logic pick_ok;
	tvd_pkg::tvd_src_t pick_src;
	logic [6:0] pick_trap;
	logic [3:0] pick_lvl;
	logic [1:0] pick_rank;
	logic [7:0] pick_clr;
	localparam logic [55:0] NODE_TRAPS = `TVD_NODE_TRAPS;

	tvd_prio_pick u_pick (
		.req(nreq),
		.en(nen_r),
		.prio(nprio_r),
		.idx(best_idx),
		.lvl(best_lvl)
	);

	always_comb
	begin
		pick_ok = 1'h1;
		pick_src = tvd_pkg::TVD_SRC_NODE;
		pick_trap = NODE_TRAPS[7*best_idx +: 7];
		pick_lvl = best_lvl;
		pick_rank = cur_rank_r;
		pick_clr = 8'h0;
		if (rst_pend_r)
		begin
			pick_src = tvd_pkg::TVD_SRC_RESET;
			pick_trap = `TVD_TRAP_RESET;
			pick_lvl = 4'h0;
			pick_rank = `TVD_RANK_NONE;
		end
		else if (trap_pend[`TVD_TFR_UNF:`TVD_TFR_NMI] != 3'h0 && cur_rank_r < `TVD_RANK_A)
		begin
			pick_src = tvd_pkg::TVD_SRC_CLASS_A;
			pick_lvl = cur_level_r;
			pick_rank = `TVD_RANK_A;
			if (trap_pend[`TVD_TFR_NMI])
			begin
				pick_trap = `TVD_TRAP_NMI;
				pick_clr = 8'h1 << `TVD_TFR_NMI;
			end
			else if (trap_pend[`TVD_TFR_OVF])
			begin
				pick_trap = `TVD_TRAP_OVF;
				pick_clr = 8'h1 << `TVD_TFR_OVF;
			end
			else
			begin
				pick_trap = `TVD_TRAP_UNF;
				pick_clr = 8'h1 << `TVD_TFR_UNF;
			end
		end
		else if (trap_pend[7:`TVD_TFR_B_LO] != 5'h0 && cur_rank_r < `TVD_RANK_B)
		begin
			pick_src = tvd_pkg::TVD_SRC_CLASS_B;
			pick_trap = `TVD_TRAP_CLASS_B;
			pick_lvl = cur_level_r;
			pick_rank = `TVD_RANK_B;
			pick_clr = 8'hf8;
		end
		else if (soft_pend_r)
		begin
			pick_src = tvd_pkg::TVD_SRC_SOFT;
			pick_trap = soft_num_r;
			pick_lvl = cur_level_r;
		end
		else if (!(cur_rank_r == `TVD_RANK_NONE && best_lvl > cur_level_r))
			pick_ok = 1'h0;
	end

	// ----------------------------------------
	// dispatcher
	// ----------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		valid_nxt = valid_r;
		off_src_nxt = off_src_r;
		off_trap_nxt = off_trap_r;
		off_lvl_nxt = off_lvl_r;
		off_rank_nxt = off_rank_r;
		off_idx_nxt = off_idx_r;
		off_clr_nxt = off_clr_r;
		cur_level_nxt = svc_return_i ? ret_level_i : cur_level_r;
		cur_rank_nxt = svc_return_i ? ret_rank_i : cur_rank_r;
		rst_pend_nxt = rst_pend_r | sw_reset_i | wdt_ovf_i;
		soft_pend_nxt = soft_pend_r | soft_trap_i;
		soft_num_nxt = (soft_trap_i && !soft_pend_r) ? soft_trap_num_i : soft_num_r;
		cause_nxt = wdt_ovf_i ? `TVD_CAUSE_WDT : (sw_reset_i ? `TVD_CAUSE_SW : cause_r);
		case (state_r)
			tvd_pkg::TVD_IDLE:
			begin
				if (pick_ok)
				begin
					state_nxt = tvd_pkg::TVD_OFFER;
					valid_nxt = 1'h1;
					off_src_nxt = pick_src;
					off_trap_nxt = pick_trap;
					off_lvl_nxt = pick_lvl;
					off_rank_nxt = pick_rank;
					off_idx_nxt = best_idx;
					off_clr_nxt = pick_clr;
				end
			end
			tvd_pkg::TVD_OFFER:
			begin
				if (disp_take_i)
				begin
					state_nxt = tvd_pkg::TVD_IDLE;
					valid_nxt = 1'h0;
					if (off_src_r != tvd_pkg::TVD_SRC_SOFT)
					begin
						cur_level_nxt = off_lvl_r;
						cur_rank_nxt = off_rank_r;
					end
					if (off_src_r == tvd_pkg::TVD_SRC_RESET)
						rst_pend_nxt = sw_reset_i | wdt_ovf_i;
					if (off_src_r == tvd_pkg::TVD_SRC_SOFT)
						soft_pend_nxt = soft_trap_i;
				end
				else if (off_src_r == tvd_pkg::TVD_SRC_NODE && pick_ok &&
					pick_src != tvd_pkg::TVD_SRC_NODE)
				begin
					state_nxt = tvd_pkg::TVD_IDLE;
					valid_nxt = 1'h0;
				end
			end
			default:
			begin
				state_nxt = tvd_pkg::TVD_IDLE;
				valid_nxt = 1'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= tvd_pkg::TVD_IDLE;
			valid_r <= 1'h0;
			off_src_r <= tvd_pkg::TVD_SRC_RESET;
			off_trap_r <= `TVD_TRAP_RESET;
			off_lvl_r <= 4'h0;
			off_rank_r <= `TVD_RANK_NONE;
			off_idx_r <= 3'h0;
			off_clr_r <= 8'h0;
			cur_level_r <= 4'h0;
			cur_rank_r <= `TVD_RANK_NONE;
			rst_pend_r <= 1'h1;
			soft_pend_r <= 1'h0;
			soft_num_r <= 7'h0;
			cause_r <= `TVD_CAUSE_HW;
			pec_r <= 1'h1;
			irq_r <= 1'h0;
		end
		else
		begin
			state_r <= state_nxt;
			valid_r <= valid_nxt;
			off_src_r <= off_src_nxt;
			off_trap_r <= off_trap_nxt;
			off_lvl_r <= off_lvl_nxt;
			off_rank_r <= off_rank_nxt;
			off_idx_r <= off_idx_nxt;
			off_clr_r <= off_clr_nxt;
			cur_level_r <= cur_level_nxt;
			cur_rank_r <= cur_rank_nxt;
			rst_pend_r <= rst_pend_nxt;
			soft_pend_r <= soft_pend_nxt;
			soft_num_r <= soft_num_nxt;
			cause_r <= cause_nxt;
			pec_r <= (cur_rank_nxt == `TVD_RANK_NONE);
			irq_r <= |(trap_flag_register & mask_r);
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign disp_valid_o = valid_r;
	assign disp_vector_o = {15'h0, off_trap_r, 2'h0};
	assign disp_trap_o = off_trap_r;
	assign disp_level_o = off_lvl_r;
	assign pec_allow_o = pec_r;
	assign irq_o = irq_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	node_vector_a: assert property (valid_r && off_src_r == tvd_pkg::TVD_SRC_NODE |->
		disp_vector_o == {15'h0, NODE_TRAPS[7*off_idx_r +: 7], 2'h0})
		else $error("node vector not four times trap number");

	trap_prompt_a: assert property (state_r == tvd_pkg::TVD_IDLE && !rst_pend_r &&
		trap_pend[`TVD_TFR_NMI] && cur_rank_r == `TVD_RANK_NONE |=>
		valid_r && disp_trap_o == `TVD_TRAP_NMI)
		else $error("pending nmi trap not offered");

	trap_wait_a: assert property ($rose(valid_r) && off_src_r == tvd_pkg::TVD_SRC_CLASS_B |->
		$past(cur_rank_r) == `TVD_RANK_NONE)
		else $error("class b trap offered during trap service");

	pec_block_a: assert property (cur_rank_r != `TVD_RANK_NONE |->
		!pec_allow_o && !($rose(valid_r) && off_src_r == tvd_pkg::TVD_SRC_NODE))
		else $error("preemption allowed during trap service");

	class_a_vec_a: assert property (valid_r && off_src_r == tvd_pkg::TVD_SRC_CLASS_A |->
		disp_vector_o inside {24'h000008, 24'h000010, 24'h000018})
		else $error("class a vector wrong");

	class_b_vec_a: assert property (valid_r && off_src_r == tvd_pkg::TVD_SRC_CLASS_B |->
		disp_vector_o == 24'h000028 && disp_trap_o == 7'h0a)
		else $error("class b vector wrong");

	reset_vec_a: assert property ((sw_reset_i || wdt_ovf_i) && state_r == tvd_pkg::TVD_IDLE &&
		!pick_ok |-> ##2 valid_r && disp_vector_o == 24'h0 && disp_trap_o == 7'h0)
		else $error("reset not vectored to zero");

	sequence s_soft_take;
		take && off_src_r == tvd_pkg::TVD_SRC_SOFT && !svc_return_i;
	endsequence
	soft_level_a: assert property (s_soft_take |=>
		cur_level_r == $past(cur_level_r) && cur_rank_r == $past(cur_rank_r))
		else $error("software trap changed cpu priority");

	node_level_a: assert property ($rose(valid_r) && off_src_r == tvd_pkg::TVD_SRC_NODE |->
		off_lvl_r > $past(cur_level_r))
		else $error("node offered without higher level");
endmodule : tvd_top
`default_nettype wire

//--- dv/tvd_cpu_model.sv
// cpu core stand-in: accepts each dispatch offer after a set delay
// assumes the tvd_top dispatch handshake on core_clk
`timescale 1ns/1ps
`default_nettype none
module tvd_cpu_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic disp_valid_o,
	input wire logic [23:0] disp_vector_o,
	input wire logic [6:0] disp_trap_o,
	input wire logic [3:0] disp_level_o,
	input wire logic [3:0] dly,
	output logic disp_take_i,
	output logic [23:0] tk_vec,
	output logic [6:0] tk_trap,
	output logic [3:0] tk_level,
	output logic [7:0] tk_cnt
);
	// ----------------------------------------
	// take handshake, recorded at the take edge
	// ----------------------------------------
	logic [3:0] wait_r;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			disp_take_i <= 1'b0;
			wait_r <= 4'h0;
			tk_vec <= 24'h0;
			tk_trap <= 7'h00;
			tk_level <= 4'h0;
			tk_cnt <= 8'h00;
		end
		else if (disp_take_i)
		begin
			disp_take_i <= 1'b0;
			wait_r <= 4'h0;
			if (disp_valid_o)
			begin
				tk_vec <= disp_vector_o;
				tk_trap <= disp_trap_o;
				tk_level <= disp_level_o;
				tk_cnt <= tk_cnt + 8'h01;
			end
		end
		else if (disp_valid_o && wait_r >= dly)
			disp_take_i <= 1'b1;
		else if (disp_valid_o)
			wait_r <= wait_r + 4'h1;
		else
			wait_r <= 4'h0;
	end
endmodule : tvd_cpu_model
`default_nettype wire

//--- dv/trap_vector_dispatch_tb_top.sv
// self-checking bench for tvd_top: traps, nodes, soft traps, registers
// assumes tvd_cpu_model takes offers; constants from tvd_cfg.svh
`timescale 1ns/1ps
`default_nettype none
`include "tvd_cfg.svh"
module trap_vector_dispatch_tb_top;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic sw_rst = 1'b0;
	logic wdt = 1'b0;
	logic strap = 1'b0;
	logic sret = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] evt = 8'h00;
	logic [7:0] nreq = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [6:0] snum = 7'h7f;
	logic [3:0] rlvl = 4'h0;
	logic [3:0] dly = 4'h0;
	logic [1:0] rrank = 2'h0;
	logic [31:0] dat_o, rd;
	logic ack, valid, peripheral_event_controller, irq, take;
	logic [23:0] vec, tk_vec;
	logic [6:0] trap, tk_trap;
	logic [3:0] lvl, tk_level;
	logic [7:0] tk_cnt;
	int bad_count = 0;
	int n_compared = 0;
	int k;
	// rows 0-7 trap events, 8-15 node pulses, 16 sw reset, 17 wdt, 18 soft trap
	logic [6:0] row_trap [19] = '{7'h02, 7'h04, 7'h06, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h0a,
		7'h20, 7'h21, 7'h2a, 7'h2b, 7'h40, 7'h41, 7'h42, 7'h43, 7'h00, 7'h00, 7'h7f};

	always #2.5 core_clk = ~core_clk;

	tvd_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .nmi_i(evt[0]), .stack_ovf_i(evt[1]), .stack_unf_i(evt[2]),
		.undef_opcode_i(evt[3]), .prot_fault_i(evt[4]), .illegal_operand_i(evt[5]),
		.illegal_instr_i(evt[6]), .illegal_bus_i(evt[7]), .sw_reset_i(sw_rst),
		.wdt_ovf_i(wdt), .node_req_i(nreq), .soft_trap_i(strap), .soft_trap_num_i(snum),
		.disp_take_i(take), .svc_return_i(sret), .ret_level_i(rlvl), .ret_rank_i(rrank),
		.disp_valid_o(valid), .disp_vector_o(vec), .disp_trap_o(trap), .disp_level_o(lvl),
		.pec_allow_o(peripheral_event_controller), .irq_o(irq));

	tvd_cpu_model u_cpu (.core_clk(core_clk), .arst_n(arst_n), .disp_valid_o(valid),
		.disp_vector_o(vec), .disp_trap_o(trap), .disp_level_o(lvl), .dly(dly),
		.disp_take_i(take), .tk_vec(tk_vec), .tk_trap(tk_trap), .tk_level(tk_level),
		.tk_cnt(tk_cnt));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		if (n >= 50)
			bad_count++;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task automatic pulse(input int i);
		@(posedge core_clk);
		if (i < 8)
			evt <= 8'h01 << i;
		else if (i < 16)
			nreq <= 8'h01 << (i - 8);
		else if (i == 16)
			sw_rst <= 1'b1;
		else if (i == 17)
			wdt <= 1'b1;
		else
			strap <= 1'b1;
		@(posedge core_clk);
		evt <= 8'h00;
		nreq <= 8'h00;
		sw_rst <= 1'b0;
		wdt <= 1'b0;
		strap <= 1'b0;
	endtask : pulse

	task automatic expect_take(input logic [6:0] t);
		logic [7:0] c0;
		int n;
		c0 = tk_cnt;
		n = 0;
		while (tk_cnt === c0 && n < 60)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 60)
			bad_count++;
		chk(tk_trap, t);
		chk(tk_vec, {15'h0, t, 2'b00});
	endtask : expect_take

	task automatic quiet();
		int h;
		h = 0;
		repeat (8)
		begin
			@(posedge core_clk);
			if (valid !== 1'b0)
				h++;
		end
		chk(h, 0);
	endtask : quiet

	task automatic ret(input logic [3:0] l, input logic [1:0] r);
		@(posedge core_clk);
		sret <= 1'b1;
		rlvl <= l;
		rrank <= r;
		@(posedge core_clk);
		sret <= 1'b0;
	endtask : ret

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge core_clk);
		chk(peripheral_event_controller, 1'b1);
		chk(valid, 1'b0);
		arst_n <= 1'b1;
		expect_take(`TVD_TRAP_RESET);
		ret(4'h0, 2'h0);
		bus(1'b0, `TVD_ADR_MASK, 32'h0);
		chk(rd, {24'h0, `TVD_RST_MASK});
		bus(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, `TVD_ADR_NEN, 32'hff);
		bus(1'b1, `TVD_ADR_NPRIO, 32'h1111_1111);
		for (k = 0; k < 19; k++)
		begin
			pulse(k);
			expect_take(row_trap[k]);
			if (k < 8)
			begin
				chk(peripheral_event_controller, 1'b0);
				bus(1'b0, `TVD_ADR_TFR, 32'h0);
				chk(rd, 32'h1 << k);
				bus(1'b1, `TVD_ADR_TFR, 32'hff);
			end
			else if (k < 16)
				chk(tk_level, 4'h1);
			else if (k < 18)
			begin
				bus(1'b0, `TVD_ADR_STAT, 32'h0);
				chk(rd[17:16], k - 15);
			end
			ret(4'h0, 2'h0);
		end
		// nmi and overflow together: overflow waits for the class A service
		@(posedge core_clk);
		evt <= 8'h03;
		@(posedge core_clk);
		evt <= 8'h00;
		expect_take(`TVD_TRAP_NMI);
		quiet();
		ret(4'h0, 2'h0);
		expect_take(`TVD_TRAP_OVF);
		ret(4'h0, 2'h0);
		// class B preempted by nmi, node held off until rank 0
		dly <= 4'h5;
		pulse(3);
		expect_take(`TVD_TRAP_CLASS_B);
		pulse(0);
		expect_take(`TVD_TRAP_NMI);
		pulse(8);
		quiet();
		ret(4'h0, 2'h1);
		quiet();
		ret(4'h0, 2'h0);
		expect_take(7'h20);
		ret(4'h0, 2'h0);
		bus(1'b1, `TVD_ADR_TFR, 32'hff);
		// levels: node0 5, node1 3, node2 7
		dly <= 4'h0;
		bus(1'b1, `TVD_ADR_NPRIO, 32'h0000_0735);
		pulse(8);
		expect_take(7'h20);
		chk(tk_level, 4'h5);
		pulse(18);
		expect_take(7'h7f);
		chk(tk_level, 4'h5);
		ret(4'h5, 2'h0);
		pulse(9);
		quiet();
		pulse(10);
		expect_take(7'h2a);
		chk(tk_level, 4'h7);
		ret(4'h5, 2'h0);
		quiet();
		ret(4'h0, 2'h0);
		expect_take(7'h21);
		chk(tk_level, 4'h3);
		ret(4'h0, 2'h0);
		// unassigned node raised by software
		bus(1'b1, `TVD_ADR_NPRIO, 32'h0100_0000);
		bus(1'b1, `TVD_ADR_NREQ, 32'h40);
		expect_take(7'h42);
		bus(1'b0, `TVD_ADR_NREQ, 32'h0);
		chk(rd, 32'h0);
		ret(4'h0, 2'h0);
		// interrupt output follows flags under mask
		bus(1'b1, `TVD_ADR_MASK, 32'h01);
		pulse(1);
		expect_take(`TVD_TRAP_OVF);
		ret(4'h0, 2'h0);
		chk(irq, 1'b0);
		pulse(0);
		expect_take(`TVD_TRAP_NMI);
		chk(irq, 1'b1);
		bus(1'b1, `TVD_ADR_TFR, 32'h01);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		ret(4'h0, 2'h0);
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end
endmodule : trap_vector_dispatch_tb_top
`default_nettype wire
